// >>> rtl/snf_pkg.sv
package snf_pkg;

    // ----------------------------------------------------------------
    // Opcodes that widen the link
    // ----------------------------------------------------------------
    localparam logic [7:0] SNF_OP_DUAL_OUT = 8'h3b;
    localparam logic [7:0] SNF_OP_DUAL_IO = 8'hbb;
    localparam logic [7:0] SNF_OP_QUAD_OUT = 8'h6b;
    localparam logic [7:0] SNF_OP_QUAD_OUT_A4 = 8'h6c;
    localparam logic [7:0] SNF_OP_QUAD_IO = 8'heb;
    localparam logic [7:0] SNF_OP_QUAD_IO_A4 = 8'hec;
    localparam logic [7:0] SNF_OP_QUAD_LOAD = 8'h32;
    localparam logic [7:0] SNF_OP_QUAD_LOAD_RND = 8'h34;

    // ----------------------------------------------------------------
    // Protection register layout and reset values
    // ----------------------------------------------------------------
    localparam int unsigned SNF_PROT_W = 8;
    localparam int unsigned SNF_HW_GUARD_BIT = 1;
    localparam logic SNF_HW_GUARD_RST = 1'b0;

    // ----------------------------------------------------------------
    // Lane layout and counts
    // ----------------------------------------------------------------
    localparam int unsigned SNF_BYTE_W = 8;
    localparam int unsigned SNF_LANES = 4;
    localparam int unsigned SNF_LINE_SERIAL_IN = 0;
    localparam int unsigned SNF_LINE_SERIAL_OUT = 1;
    localparam int unsigned SNF_LINE_GUARD = 2;
    localparam int unsigned SNF_LINE_PAUSE = 3;
    localparam logic [3:0] SNF_OE_W1 = 4'h2;
    localparam logic [3:0] SNF_OE_W2 = 4'h3;
    localparam logic [3:0] SNF_OE_W4 = 4'hf;
    localparam logic [3:0] SNF_OE_NONE = 4'h0;

    typedef enum logic [1:0] {SNF_W1, SNF_W2, SNF_W4} snf_width_t;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic first;
        logic [7:0] data;
    } snf_rx_t;

    typedef struct packed {
        logic [3:0] dout;
        logic [3:0] oe;
    } snf_pad_t;

    function automatic snf_width_t snf_op_width(input logic [7:0] op);
        snf_width_t w;
        w = SNF_W1;
        if (op == SNF_OP_DUAL_OUT || op == SNF_OP_DUAL_IO) begin
            w = SNF_W2;
        end
        if (op == SNF_OP_QUAD_OUT || op == SNF_OP_QUAD_OUT_A4 ||
            op == SNF_OP_QUAD_IO || op == SNF_OP_QUAD_IO_A4 ||
            op == SNF_OP_QUAD_LOAD || op == SNF_OP_QUAD_LOAD_RND) begin
            w = SNF_W4;
        end
        return w;
    endfunction

    function automatic logic [3:0] snf_step(input snf_width_t w);
        logic [3:0] s;
        s = 4'h1;
        if (w == SNF_W2) begin
            s = 4'h2;
        end
        if (w == SNF_W4) begin
            s = 4'h4;
        end
        return s;
    endfunction

endpackage

// >>> rtl/snf_lanes.sv
`timescale 1ns/1ps
module snf_lanes
    import snf_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Frame control
    input wire logic i_clear,
    input wire logic i_rise,
    input wire logic i_fall,
    input wire logic i_tx_on,
    input wire snf_pkg::snf_width_t i_width,
    // Data
    input wire logic [3:0] i_din,
    input wire logic [7:0] i_tx_byte,
    output snf_pkg::snf_rx_t o_rx,
    output logic o_tx_take,
    output logic [3:0] o_tx_bits
);

    logic [7:0] rx_q, rx_d;
    logic [2:0] rcnt_q, rcnt_d;
    logic first_q, first_d;
    snf_rx_t out_q, out_d;
    logic [7:0] tx_q, tx_d;
    logic [2:0] tcnt_q, tcnt_d;
    logic take_q, take_d;
    logic [3:0] step;
    logic [3:0] rsum;
    logic [3:0] tsum;

    assign step = snf_step(i_width);
    assign rsum = {1'b0, rcnt_q} + step;
    assign tsum = {1'b0, tcnt_q} + step;

    // ----------------------------------------------------------------
    // Receive: sample on rising edge, most significant bit first
    // ----------------------------------------------------------------
    always_comb begin
        rx_d = rx_q;
        rcnt_d = rcnt_q;
        first_d = first_q;
        out_d = out_q;
        out_d.valid = 1'b0;
        if (i_clear) begin
            rcnt_d = 3'h0;
            first_d = 1'b1;
        end else if (i_rise) begin
            unique case (i_width)
                SNF_W1: rx_d = {rx_q[6:0], i_din[SNF_LINE_SERIAL_IN]};
                SNF_W2: rx_d = {rx_q[5:0], i_din[1:0]};
                SNF_W4: rx_d = {rx_q[3:0], i_din};
            endcase
            rcnt_d = rsum[2:0];
            if (rsum[3]) begin
                out_d.valid = 1'b1;
                out_d.first = first_q;
                out_d.data = rx_d;
                first_d = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rx_q <= 8'h00;
            rcnt_q <= 3'h0;
            first_q <= 1'b1;
            out_q <= '0;
        end else begin
            rx_q <= rx_d;
            rcnt_q <= rcnt_d;
            first_q <= first_d;
            out_q <= out_d;
        end
    end

    // ----------------------------------------------------------------
    // Transmit: launch on falling edge, new byte when count wraps
    // ----------------------------------------------------------------
    always_comb begin
        tx_d = tx_q;
        tcnt_d = tcnt_q;
        take_d = 1'b0;
        if (i_clear || !i_tx_on) begin
            tcnt_d = 3'h0;
        end else if (i_fall) begin
            if (tcnt_q == 3'h0) begin
                tx_d = i_tx_byte;
                take_d = 1'b1;
                tcnt_d = step[2:0];
            end else begin
                unique case (i_width)
                    SNF_W1: tx_d = {tx_q[6:0], 1'b0};
                    SNF_W2: tx_d = {tx_q[5:0], 2'b00};
                    SNF_W4: tx_d = {tx_q[3:0], 4'h0};
                endcase
                tcnt_d = tsum[2:0];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tx_q <= 8'h00;
            tcnt_q <= 3'h0;
            take_q <= 1'b0;
        end else begin
            tx_q <= tx_d;
            tcnt_q <= tcnt_d;
            take_q <= take_d;
        end
    end

    assign o_rx = out_q;
    assign o_tx_take = take_q;
    assign o_tx_bits = tx_q[7:4];

endmodule

// >>> rtl/snf_front.sv
`timescale 1ns/1ps
// Operation
// - Deselected: all data lines floated
// - Internal operations survive select going high
// - Ignore commands until select falls once
// - Single line: sample input on rising clock
// - Single line: launch output on falling clock
// - Wide lines: sample rising, launch falling
// - Accept clock modes 0 and 3
// - Dual opcodes turn two serial lines bidirectional
// - Quad opcodes use all four lines
// - Guard enable 0: guard pin shields protection register
// - Guard enable 1: guard pin low blocks writes
// - Guard enable 1: refuse quad operations
// - Pause floats output, ignores input and clock
// - Pause entry waits for clock low
// - Pause exit waits for clock low
// - Pause keeps partial command and data
// - Quad transfer: pause pin is data line
// - Guard enable is protection bit 1, default 0
module snf_front
    import snf_pkg::*;
(
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    // Serial link pins
    input wire logic I_SCLK,
    input wire logic I_CS_N,
    input wire logic [3:0] I_DL,
    output snf_pkg::snf_pad_t O_PAD,
    // Core side: protection register and transmit
    input wire logic [7:0] I_PROT_REG,
    input wire logic I_OUT_PHASE,
    input wire logic I_PHASE_WIDE,
    input wire logic [7:0] I_TX_DATA,
    output logic O_TX_TAKE,
    // Core side: receive and frame status
    output snf_pkg::snf_rx_t O_RX,
    output logic O_FRAME_START,
    output logic O_FRAME_END,
    output logic O_QUAD_REJECT,
    output snf_pkg::snf_width_t O_WIDTH,
    output logic O_PAUSED,
    // Core side: write guards
    output logic O_GUARD_ALL,
    output logic O_GUARD_PROT_REG
);

    typedef enum logic [1:0] {ST_DESEL, ST_OPCODE, ST_BODY, ST_REJECT} snf_state_t;

    snf_state_t state_q, state_d;
    snf_width_t cls_q, cls_d;
    logic armed_q, armed_d;
    logic sclk_q;
    logic hold_q, hold_d;
    logic start_q, start_d;
    logic end_q, end_d;
    logic rej_q, rej_d;
    snf_rx_t rx_q, rx_d;
    snf_pad_t pad_q, pad_d;
    logic gall_q, gall_d;
    logic gprot_q, gprot_d;
    logic hw_guard;
    logic rise_raw, fall_raw;
    logic rise, fall;
    logic quad_body;
    logic hold_ok;
    logic tx_on;
    snf_width_t width;
    snf_rx_t lane_rx;
    logic lane_take;
    logic [3:0] tx_bits;

    // ----------------------------------------------------------------
    // Clock edges and mode decode
    // ----------------------------------------------------------------
    // The previous sample follows the pin at all times, so an idle clock
    // level of either polarity at select fall creates no edge.
    assign rise_raw = !sclk_q && I_SCLK;
    assign fall_raw = sclk_q && !I_SCLK;
    assign rise = rise_raw && !hold_q && state_q != ST_DESEL;
    assign fall = fall_raw && !hold_q && state_q != ST_DESEL;

    assign hw_guard = I_PROT_REG[SNF_HW_GUARD_BIT];
    assign quad_body = state_q == ST_BODY && cls_q == SNF_W4;
    assign tx_on = state_q == ST_BODY && I_OUT_PHASE;

    always_comb begin
        width = SNF_W1;
        if (state_q == ST_BODY && I_PHASE_WIDE) begin
            width = cls_q;
        end
    end

    // ----------------------------------------------------------------
    // Frame state
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        cls_d = cls_q;
        armed_d = armed_q;
        start_d = 1'b0;
        end_d = 1'b0;
        rej_d = 1'b0;
        if (I_CS_N) begin
            armed_d = 1'b1;
        end
        if (I_CS_N) begin
            // Only the front end is torn down; the core runs on
            state_d = ST_DESEL;
            cls_d = SNF_W1;
            end_d = state_q != ST_DESEL;
        end else begin
            unique case (state_q)
                ST_DESEL: begin
                    if (armed_q) begin
                        state_d = ST_OPCODE;
                        start_d = 1'b1;
                    end
                end
                ST_OPCODE: begin
                    if (lane_rx.valid) begin
                        cls_d = snf_op_width(lane_rx.data);
                        if (cls_d == SNF_W4 && hw_guard) begin
                            state_d = ST_REJECT;
                            rej_d = 1'b1;
                        end else begin
                            state_d = ST_BODY;
                        end
                    end
                end
                ST_BODY: begin
                    state_d = ST_BODY;
                end
                ST_REJECT: begin
                    state_d = ST_REJECT;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            state_q <= ST_DESEL;
            cls_q <= SNF_W1;
            armed_q <= 1'b0;
            sclk_q <= 1'b0;
            start_q <= 1'b0;
            end_q <= 1'b0;
            rej_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cls_q <= cls_d;
            armed_q <= armed_d;
            sclk_q <= I_SCLK;
            start_q <= start_d;
            end_q <= end_d;
            rej_q <= rej_d;
        end
    end

    // ----------------------------------------------------------------
    // Pause
    // ----------------------------------------------------------------
    // A change of the pause pin takes effect only while the clock is low;
    // with the clock high it waits for the falling edge, which counts on entry but is ignored on exit.
    assign hold_ok = state_q != ST_DESEL && !quad_body;

    always_comb begin
        hold_d = hold_q;
        if (!hold_ok) begin
            hold_d = 1'b0;
        end else if (!I_SCLK) begin
            hold_d = !I_DL[SNF_LINE_PAUSE];
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            hold_q <= 1'b0;
        end else begin
            hold_q <= hold_d;
        end
    end

    // ----------------------------------------------------------------
    // Shift lanes
    // ----------------------------------------------------------------
    // Lane state is never cleared by a pause; a new frame clears it, and the transmit count also clears while the output phase is off.
    snf_lanes u_lanes (
        .i_clk(I_CLK),
        .i_rst(I_SYS_RST),
        .i_clear(start_d),
        .i_rise(rise),
        .i_fall(fall),
        .i_tx_on(tx_on),
        .i_width(width),
        .i_din(I_DL),
        .i_tx_byte(I_TX_DATA),
        .o_rx(lane_rx),
        .o_tx_take(lane_take),
        .o_tx_bits(tx_bits)
    );

    always_comb begin
        rx_d = lane_rx;
        if (state_q != ST_OPCODE && state_q != ST_BODY) begin
            rx_d.valid = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Pad drive
    // ----------------------------------------------------------------
    always_comb begin
        pad_d.dout = 4'h0;
        pad_d.oe = SNF_OE_NONE;
        if (!I_CS_N && tx_on && !hold_d) begin
            unique case (width)
                SNF_W1: begin
                    pad_d.dout[SNF_LINE_SERIAL_OUT] = tx_bits[3];
                    pad_d.oe = SNF_OE_W1;
                end
                SNF_W2: begin
                    pad_d.dout[1:0] = tx_bits[3:2];
                    pad_d.oe = SNF_OE_W2;
                end
                SNF_W4: begin
                    pad_d.dout = tx_bits;
                    pad_d.oe = SNF_OE_W4;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Write guards
    // ----------------------------------------------------------------
    // While the guard pin carries quad data its level means nothing,
    // so the last guard decision is held through the transfer.
    always_comb begin
        gall_d = gall_q;
        gprot_d = gprot_q;
        if (!quad_body) begin
            gall_d = hw_guard && !I_DL[SNF_LINE_GUARD];
            gprot_d = !hw_guard && !I_DL[SNF_LINE_GUARD];
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            rx_q <= '0;
            pad_q <= '0;
            gall_q <= SNF_HW_GUARD_RST;
            gprot_q <= 1'b0;
        end else begin
            rx_q <= rx_d;
            pad_q <= pad_d;
            gall_q <= gall_d;
            gprot_q <= gprot_d;
        end
    end

    assign O_PAD = pad_q;
    assign O_RX = rx_q;
    assign O_TX_TAKE = lane_take;
    assign O_FRAME_START = start_q;
    assign O_FRAME_END = end_q;
    assign O_QUAD_REJECT = rej_q;
    assign O_WIDTH = cls_q;
    assign O_PAUSED = hold_q;
    assign O_GUARD_ALL = gall_q;
    assign O_GUARD_PROT_REG = gprot_q;

endmodule

// >>> test/snf_front_props.sv
`timescale 1ns/1ps
module snf_front_props
    import snf_pkg::*;
(
    // Link pins
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_SCLK,
    input wire logic I_CS_N,
    input wire logic [3:0] I_DL,
    input wire logic [7:0] I_PROT_REG,
    // Design outputs
    input wire snf_pkg::snf_pad_t O_PAD,
    input wire snf_pkg::snf_rx_t O_RX,
    input wire logic O_TX_TAKE,
    input wire logic O_FRAME_START,
    input wire logic O_FRAME_END,
    input wire logic O_QUAD_REJECT,
    input wire snf_pkg::snf_width_t O_WIDTH,
    input wire logic O_PAUSED,
    input wire logic O_GUARD_ALL,
    input wire logic O_GUARD_PROT_REG
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);

    sequence hold_ok;
        !I_CS_N && O_WIDTH != SNF_W4;
    endsequence
    sequence enter_hi;
        hold_ok ##0 I_SCLK && $fell(I_DL[3]) && !O_PAUSED;
    endsequence

    a_desel_float: assert property (I_CS_N [*3] |-> O_PAD.oe == SNF_OE_NONE)
        else $error("pads driven while deselected");
    a_start_timing: assert property (O_FRAME_START |-> !$past(I_CS_N, 1) && $past(I_CS_N, 2))
        else $error("frame start not one cycle after select fell");
    a_end_timing: assert property (O_FRAME_END |-> $past(I_CS_N, 1) && !$past(I_CS_N, 2))
        else $error("frame end not one cycle after select rose");
    a_guard_all: assert property ((I_CS_N && $stable(I_DL[2]) && $stable(I_PROT_REG)) [*3]
        |-> O_GUARD_ALL == (I_PROT_REG[1] && !I_DL[2])) else $error("write guard wrong");
    a_guard_prot: assert property ((I_CS_N && $stable(I_DL[2]) && $stable(I_PROT_REG)) [*3]
        |-> O_GUARD_PROT_REG == (!I_PROT_REG[1] && !I_DL[2])) else $error("register guard wrong");
    a_quad_refuse: assert property (O_QUAD_REJECT |-> I_PROT_REG[1] && !I_CS_N)
        else $error("quad refused with guard enable clear");
    a_pause_floats: assert property (O_PAUSED [*2] |-> O_PAD.oe == SNF_OE_NONE)
        else $error("output driven during pause");
    a_pause_enter: assert property (hold_ok ##0 !I_SCLK && $fell(I_DL[3]) |-> ##[1:3] O_PAUSED)
        else $error("pause did not start with clock low");
    a_pause_waits: assert property (enter_hi ##1 I_SCLK [*2] |-> !O_PAUSED)
        else $error("pause started while clock high");
    a_pause_leave: assert property (O_PAUSED && !I_CS_N && !I_SCLK && $rose(I_DL[3])
        |-> ##[1:3] !O_PAUSED) else $error("pause did not end with clock low");
    a_take_fall: assert property (O_TX_TAKE |-> !$past(I_SCLK) ##1 !O_TX_TAKE)
        else $error("byte load not after falling clock");
    a_pad_launch: assert property (!I_CS_N && O_PAD.oe != SNF_OE_NONE
        && $past(O_PAD.oe) != SNF_OE_NONE && $changed(O_PAD.dout) |-> !$past(I_SCLK, 2))
        else $error("output changed away from falling clock");
    a_width_dual: assert property (O_RX.valid && O_RX.first && (O_RX.data == SNF_OP_DUAL_OUT
        || O_RX.data == SNF_OP_DUAL_IO) |-> ##[0:2] O_WIDTH == SNF_W2) else $error("no dual");
endmodule

bind snf_front snf_front_props props_u (.I_CLK, .I_SYS_RST, .I_SCLK, .I_CS_N, .I_DL,
    .I_PROT_REG, .O_PAD, .O_RX, .O_TX_TAKE, .O_FRAME_START, .O_FRAME_END, .O_QUAD_REJECT,
    .O_WIDTH, .O_PAUSED, .O_GUARD_ALL, .O_GUARD_PROT_REG);

// >>> test/snf_host.sv
`timescale 1ns/1ps
module snf_host (
    // Clock and resolved lines
    input wire logic i_clk,
    input wire logic [3:0] i_dl,
    // Link pins
    output logic o_sclk,
    output logic o_cs_n,
    output logic [3:0] o_dl
);
    logic [3:0] hv;
    logic [3:0] hen;
    logic cpol;

    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b0;
        hv = 4'hf;
        hen = 4'hd;
        cpol = 1'b0;
    end
    // Released lines show the inverse of their last value, never a stale copy
    assign o_dl = ~(hv ^ hen);

    task automatic half();
        repeat (4) @(negedge i_clk);
    endtask

    task automatic sel(input logic v);
        o_sclk = cpol;
        half();
        o_cs_n = v;
        half();
        if (v) begin
            hv = 4'hf;
            hen = 4'hd;
        end
    endtask

    task automatic pin(input int k, input logic v);
        hv[k] = v;
        half();
    endtask

    task automatic tick(input logic v);
        o_sclk = v;
        half();
    endtask

    task automatic xfer(input int w, input int n, input logic rd, input logic [7:0] tx,
                        output logic [7:0] rx);
        logic [7:0] s;
        s = tx;
        rx = 8'h00;
        hen = (w == 1) ? 4'hd : (w == 2) ? (rd ? 4'hc : 4'hf) : (rd ? 4'h0 : 4'hf);
        for (int i = 0; i < n; i += w) begin
            o_sclk = 1'b0;
            case (w)
                1: hv[0] = s[7];
                2: hv[1:0] = s[7:6];
                default: hv = s[7:4];
            endcase
            s = s << w;
            half();
            o_sclk = 1'b1;
            half();
            case (w)
                1: rx = {rx[6:0], i_dl[1]};
                2: rx = {rx[5:0], i_dl[1:0]};
                default: rx = {rx[3:0], i_dl};
            endcase
        end
    endtask
endmodule

// >>> test/testbench.sv
`timescale 1ns/1ps
module testbench;
    import snf_pkg::*;
    localparam logic [7:0] OPS [8] = '{SNF_OP_DUAL_OUT, SNF_OP_DUAL_IO, SNF_OP_QUAD_OUT,
        SNF_OP_QUAD_OUT_A4, SNF_OP_QUAD_IO, SNF_OP_QUAD_IO_A4, SNF_OP_QUAD_LOAD,
        SNF_OP_QUAD_LOAD_RND};
    logic I_CLK;
    logic I_SYS_RST;
    logic [7:0] prot;
    logic out_ph;
    logic wide;
    logic [7:0] txd;
    logic sclk, cs_n, take, fstart, fend, qrej, paused, g_all, g_prot, last_first;
    logic [3:0] hdl, dl;
    logic [7:0] last_rx, got, tail;
    snf_pad_t pad;
    snf_rx_t rx;
    snf_width_t width;
    int fails = 0;
    int n_tests = 0;
    int n_rx, n_start, n_end, n_take, n_rej;

    always #10 I_CLK = ~I_CLK;
    assign dl = (pad.oe & pad.dout) | (~pad.oe & hdl);

    snf_host host_u (.i_clk(I_CLK), .i_dl(dl), .o_sclk(sclk), .o_cs_n(cs_n), .o_dl(hdl));
    snf_front dut_u (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_SCLK(sclk), .I_CS_N(cs_n),
        .I_DL(dl), .O_PAD(pad), .I_PROT_REG(prot), .I_OUT_PHASE(out_ph), .I_PHASE_WIDE(wide),
        .I_TX_DATA(txd), .O_TX_TAKE(take), .O_RX(rx), .O_FRAME_START(fstart),
        .O_FRAME_END(fend), .O_QUAD_REJECT(qrej), .O_WIDTH(width), .O_PAUSED(paused),
        .O_GUARD_ALL(g_all), .O_GUARD_PROT_REG(g_prot));

    always @(posedge I_CLK) begin
        n_rx += int'(rx.valid);
        n_start += int'(fstart);
        n_end += int'(fend);
        n_take += int'(take);
        n_rej += int'(qrej);
        if (rx.valid === 1'b1) begin
            last_rx = rx.data;
            last_first = rx.first;
        end
    end

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic clr();
        n_rx = 0;
        n_start = 0;
        n_end = 0;
        n_take = 0;
        n_rej = 0;
    endtask

    task automatic stop_test();
        $display("Counts: %0d checks, %0d mismatches", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Bounded wait for a received byte; a stuck receiver ends the run
    task automatic await_rx();
        for (int k = 0; k < 40 && n_rx == 0; k++) begin
            @(negedge I_CLK);
        end
        if (n_rx == 0) begin
            fails++;
            $display("MISMATCH rx_wait expected 1 seen 0");
            stop_test();
        end
    endtask

    initial begin
        I_CLK = 1'b0;
        I_SYS_RST = 1'b1;
        prot = 8'h00;
        out_ph = 1'b0;
        wide = 1'b0;
        txd = 8'h00;
        repeat (3) @(negedge I_CLK);
        I_SYS_RST = 1'b0;
        clr();
        host_u.xfer(1, 8, 1'b0, 8'ha5, got);
        repeat (8) @(negedge I_CLK);
        chk("unarmed_start", 8'(n_start), 8'h00);
        chk("unarmed_rx", 8'(n_rx), 8'h00);
        host_u.sel(1'b1);
        $display("test unarmed done");
        for (int k = 0; k < 4; k++) begin
            prot = {6'h00, k[0], 1'b0};
            host_u.pin(2, k[1]);
            chk("guard_all", {7'h00, g_all}, {7'h00, k[0] & ~k[1]});
            chk("guard_prot", {7'h00, g_prot}, {7'h00, ~k[0] & ~k[1]});
        end
        prot = 8'h00;
        host_u.pin(2, 1'b1);
        $display("test guards done");
        for (int m = 0; m < 2; m++) begin
            host_u.cpol = m[0];
            clr();
            host_u.sel(1'b0);
            host_u.xfer(1, 8, 1'b0, 8'hc3, got);
            await_rx();
            chk("opcode", last_rx, 8'hc3);
            chk("opcode_first", {7'h00, last_first}, 8'h01);
            out_ph = 1'b1;
            txd = 8'h96;
            host_u.xfer(1, 4, 1'b0, 8'h00, got);
            chk("out_en", {4'h0, pad.oe}, {4'h0, SNF_OE_W1});
            host_u.pin(3, 1'b0);
            chk("pause_wait", {7'h00, paused}, 8'h00);
            host_u.tick(1'b0);
            chk("pause_on", {7'h00, paused}, 8'h01);
            chk("pause_float", {4'h0, pad.oe}, 8'h00);
            host_u.tick(1'b1);
            host_u.tick(1'b0);
            host_u.pin(3, 1'b1);
            chk("pause_off", {7'h00, paused}, 8'h00);
            // Clock already low: entry and exit follow the pause pin at once
            host_u.pin(3, 1'b0);
            chk("pause_low_on", {7'h00, paused}, 8'h01);
            chk("pause_low_float", {4'h0, pad.oe}, 8'h00);
            host_u.pin(3, 1'b1);
            chk("pause_low_off", {7'h00, paused}, 8'h00);
            host_u.xfer(1, 4, 1'b0, 8'h00, tail);
            chk("read_byte", {got[3:0], tail[3:0]}, 8'h96);
            chk("tx_take", 8'(n_take), 8'h01);
            out_ph = 1'b0;
            host_u.sel(1'b1);
            chk("frame_start", 8'(n_start), 8'h01);
            chk("frame_end", 8'(n_end), 8'h01);
            chk("desel_float", {4'h0, pad.oe}, 8'h00);
        end
        $display("test single line done");
        host_u.cpol = 1'b0;
        foreach (OPS[k]) begin
            clr();
            host_u.sel(1'b0);
            host_u.xfer(1, 8, 1'b0, OPS[k], got);
            await_rx();
            chk("width", {6'h00, width}, {6'h00, (k < 2) ? SNF_W2 : SNF_W4});
            wide = 1'b1;
            out_ph = (k < 6);
            txd = ~OPS[k];
            clr();
            host_u.xfer((k < 2) ? 2 : 4, 8, k < 6, OPS[k] ^ 8'h3c, got);
            if (k < 6) begin
                chk("wide_read", got, ~OPS[k]);
                chk("wide_oe", {4'h0, pad.oe}, {4'h0, (k < 2) ? SNF_OE_W2 : SNF_OE_W4});
            end else begin
                await_rx();
                chk("quad_load", last_rx, OPS[k] ^ 8'h3c);
            end
            chk("quad_no_pause", {7'h00, paused}, 8'h00);
            host_u.sel(1'b1);
            wide = 1'b0;
            out_ph = 1'b0;
        end
        $display("test wide opcodes done");
        prot = 8'h02;
        clr();
        host_u.sel(1'b0);
        host_u.xfer(1, 8, 1'b0, SNF_OP_QUAD_IO, got);
        repeat (8) @(negedge I_CLK);
        chk("quad_reject", 8'(n_rej), 8'h01);
        n_rx = 0;
        host_u.xfer(1, 8, 1'b0, 8'h81, got);
        repeat (8) @(negedge I_CLK);
        chk("reject_rx", 8'(n_rx), 8'h00);
        host_u.sel(1'b1);
        $display("test quad refusal done");
        stop_test();
    end
endmodule
